// [hw/jkff_pkg.sv]
// types and constants shared by the dual j-k flip-flop block.
// assumes a single 100 MHz system clock; the element clock arrives as a pin.
package jkff_pkg;
  localparam int unsigned ELEM_COUNT   = 2;
  localparam int unsigned SYNC_STAGES  = 3;
  localparam logic        CLK_LVL_RST  = 1'b0;
  localparam logic        TRUE_RST     = 1'b0;
  localparam logic        COMPL_RST    = 1'b1;
  localparam logic [2:0]  SYNC_ST_RST  = 3'h0;

  // per-element inputs from surrounding logic
  typedef struct packed {
    logic j;
    logic k;
    logic preset_n;
  } jkff_elem_in_t;

  // synchroniser state: raw pin stages and the settled level
  typedef struct packed {
    logic [SYNC_STAGES-1:0] stage;
    logic                   lvl;
  } jkff_sync_st_t;

  // core state: previous settled clock level and both elements' outputs
  typedef struct packed {
    logic                  clk_prev;
    logic [ELEM_COUNT-1:0] q;
    logic [ELEM_COUNT-1:0] q_n;
  } jkff_core_st_t;
endpackage

// [hw/jkff_sync.sv]
// three-stage synchroniser for one pin from outside the clk domain.
// assumes clk is free running; the settled level moves only when stages two
// and three agree, so a single-cycle glitch past stage one is filtered out.
`timescale 1ns/10ps
module jkff_sync
#(
  parameter logic RST_LVL = 1'b0
)
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_raw,
  output logic      lvl
);
  jkff_pkg::jkff_sync_st_t st_r;
  jkff_pkg::jkff_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.stage = {st_r.stage[1:0], pin_raw};
    // stage 0 is read only by stage 1
    if (st_r.stage[1] == st_r.stage[2])
    begin
      st_nxt.lvl = st_r.stage[2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r.stage <= jkff_pkg::SYNC_ST_RST;
      st_r.lvl   <= RST_LVL;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign lvl = st_r.lvl;
endmodule

// [hw/jkff_dual.sv]
// dual j-k flip-flop with per-element preset and shared clear and clock.
// assumes j, k, presets and clear come from logic on clk; the element clock
// is a pin from outside and is synchronised before its falling edge is used.
//
// Function
// - two elements, shared clock and clear, own presets
// - low preset sets, low clear resets, clock ignored
// - both low gives both outputs high, not kept
// - update only on falling clock, else hold
// - jk 00 hold, 10 set, 01 reset
// - jk 11 toggles, divides clock by two
// - later j/k changes wait for next edge
`timescale 1ns/10ps
module jkff_dual
#(
  parameter int unsigned ELEMS = jkff_pkg::ELEM_COUNT
)
(
  input  wire logic                                    clk,
  input  wire logic                                    sys_rst,
  input  wire logic                                    elem_clk_pin,
  input  wire logic                                    shared_force_zero_n,
  input  wire jkff_pkg::jkff_elem_in_t [ELEMS-1:0]     elem_in,
  output logic                         [ELEMS-1:0]     q,
  output logic                         [ELEMS-1:0]     q_n
);
  jkff_pkg::jkff_core_st_t st_r;
  jkff_pkg::jkff_core_st_t st_nxt;
  logic                    clk_lvl;
  logic                    fall;

  // next true output for a qualifying edge
  function automatic logic jk_next(input logic cur, input logic j, input logic k);
    logic r;
    r = cur;
    unique case ({j, k})
      2'b00: r = cur;
      2'b10: r = 1'b1;
      2'b01: r = 1'b0;
      2'b11: r = ~cur;
    endcase
    return r;
  endfunction

  jkff_sync
  #(
    .RST_LVL (jkff_pkg::CLK_LVL_RST)
  )
  u_clk_sync
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_raw (elem_clk_pin),
    .lvl     (clk_lvl)
  );

  // the shared clock edge seen once for both elements
  // a pin pulse shorter than two clk cycles can be lost in the synchroniser
  assign fall = st_r.clk_prev & ~clk_lvl;

  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.clk_prev = clk_lvl;
    for (int i = 0; i < ELEMS; i++)
    begin
      // overrides are checked every cycle, independent of the element clock
      if (!elem_in[i].preset_n && !shared_force_zero_n)
      begin
        st_nxt.q[i]   = 1'b1;
        st_nxt.q_n[i] = 1'b1;
      end
      else if (!elem_in[i].preset_n)
      begin
        st_nxt.q[i]   = 1'b1;
        st_nxt.q_n[i] = 1'b0;
      end
      else if (!shared_force_zero_n)
      begin
        st_nxt.q[i]   = 1'b0;
        st_nxt.q_n[i] = 1'b1;
      end
      else
      begin
        // j and k are looked at only in the edge cycle
        if (fall)
        begin
          st_nxt.q[i] = jk_next(st_r.q[i], elem_in[i].j, elem_in[i].k);
        end
        // restores complement after the nonstable both-high state
        st_nxt.q_n[i] = ~st_nxt.q[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r.clk_prev <= jkff_pkg::CLK_LVL_RST;
      st_r.q        <= {ELEMS{jkff_pkg::TRUE_RST}};
      st_r.q_n      <= {ELEMS{jkff_pkg::COMPL_RST}};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q   = st_r.q;
  assign q_n = st_r.q_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic inact0;
  assign inact0 = elem_in[0].preset_n && shared_force_zero_n;
  logic inact1;
  assign inact1 = elem_in[1].preset_n && shared_force_zero_n;

  property p_shared_clear;
    !shared_force_zero_n && elem_in[0].preset_n && elem_in[1].preset_n
      |=> q == 2'b00 && q_n == 2'b11;
  endproperty
  a_shared_clear: assert property (p_shared_clear)
    else $error("shared clear did not reset both elements");

  property p_preset;
    !elem_in[0].preset_n && shared_force_zero_n |=> q[0] && !q_n[0];
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset did not set element 0");

  property p_nonstable;
    !elem_in[1].preset_n && !shared_force_zero_n
      ##1 (elem_in[1].preset_n || shared_force_zero_n)
      |-> q[1] && q_n[1] ##1 q_n[1] != q[1];
  endproperty
  a_nonstable: assert property (p_nonstable)
    else $error("both-high state wrong or retained");

  property p_hold_no_edge;
    inact0 && !fall |=> $stable(q[0]);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge)
    else $error("element 0 changed without a falling clock");

  property p_set_reset;
    inact0 && fall && (elem_in[0].j != elem_in[0].k) |=> q[0] == $past(elem_in[0].j);
  endproperty
  a_set_reset: assert property (p_set_reset)
    else $error("set or reset on edge wrong");

  property p_toggle;
    inact0 && fall && elem_in[0].j && elem_in[0].k |=> q[0] != $past(q[0]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle on edge missed");

  property p_jk_late;
    inact0 && !fall && ($changed(elem_in[0].j) || $changed(elem_in[0].k)) ##1 inact0 && !fall
      |=> $stable(q[0]);
  endproperty
  a_jk_late: assert property (p_jk_late)
    else $error("late j/k change reached output");

  property p_complement;
    elem_in[1].preset_n || shared_force_zero_n |=> q_n[1] == ~q[1];
  endproperty
  a_complement: assert property (p_complement)
    else $error("complement output not inverse");

  property p_preset_el1;
    !elem_in[1].preset_n && shared_force_zero_n |=> q[1] && !q_n[1];
  endproperty
  a_preset_el1: assert property (p_preset_el1)
    else $error("preset did not set element 1");

  property p_hold_no_edge_el1;
    inact1 && !fall |=> $stable(q[1]);
  endproperty
  a_hold_no_edge_el1: assert property (p_hold_no_edge_el1)
    else $error("element 1 changed without a falling clock");

  property p_set_reset_el1;
    inact1 && fall && (elem_in[1].j != elem_in[1].k) |=> q[1] == $past(elem_in[1].j);
  endproperty
  a_set_reset_el1: assert property (p_set_reset_el1)
    else $error("set or reset on edge wrong for element 1");

  property p_toggle_el1;
    inact1 && fall && elem_in[1].j && elem_in[1].k |=> q[1] != $past(q[1]);
  endproperty
  a_toggle_el1: assert property (p_toggle_el1)
    else $error("toggle on edge missed for element 1");

  property p_jk_late_el1;
    inact1 && !fall && ($changed(elem_in[1].j) || $changed(elem_in[1].k)) ##1 inact1 && !fall
      |=> $stable(q[1]);
  endproperty
  a_jk_late_el1: assert property (p_jk_late_el1)
    else $error("late j/k change reached output of element 1");

  property p_complement_el0;
    elem_in[0].preset_n || shared_force_zero_n |=> q_n[0] == ~q[0];
  endproperty
  a_complement_el0: assert property (p_complement_el0)
    else $error("complement output of element 0 not inverse");

  // both elements must react to the one shared edge in the same cycle
  property p_shared_edge;
    inact0 && inact1 && fall && elem_in[0].j && elem_in[0].k && elem_in[1].j && elem_in[1].k
      |=> q == ~$past(q);
  endproperty
  a_shared_edge: assert property (p_shared_edge)
    else $error("elements did not toggle together on the shared edge");

  c_toggle: cover property (inact0 && fall && elem_in[0].j && elem_in[0].k);
  c_nonstable: cover property (!elem_in[0].preset_n && !shared_force_zero_n);
  c_clear: cover property (!shared_force_zero_n ##1 shared_force_zero_n);
  c_preset_el1: cover property (!elem_in[1].preset_n && shared_force_zero_n);
  c_release_both: cover property (!inact1 && !elem_in[1].preset_n ##1 inact1);
endmodule

// [test/jkff_dual_tb.sv]
// self-checking bench for the dual j-k flip-flop block.
// assumes jkff_dual and jkff_pkg; all inputs change on the falling clk edge.
`timescale 1ns/10ps
module jkff_dual_tb;
  logic                          clk;
  logic                          sys_rst;
  logic                          pin;
  logic                          clr_n;
  jkff_pkg::jkff_elem_in_t [1:0] ein;
  logic [1:0]                    q;
  logic [1:0]                    q_n;
  int                            n_mismatch;
  int                            comparisons;

  jkff_dual DUT
  (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .elem_clk_pin        (pin),
    .shared_force_zero_n (clr_n),
    .elem_in             (ein),
    .q                   (q),
    .q_n                 (q_n)
  );

  always #5 clk = ~clk;

  task summarize;
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [1:0] eq, input logic [1:0] eqn);
    comparisons++;
    if (q !== eq || q_n !== eqn)
    begin
      n_mismatch++;
      $display("[FAIL] q,q_n exp %b,%b got %b,%b", eq, eqn, q, q_n);
    end
  endtask

  // overrides land one cycle later; three cycles leaves margin
  task drv(input logic [1:0] j, input logic [1:0] k, input logic [1:0] p_n, input logic c_n);
    @(negedge clk);
    for (int i = 0; i < 2; i++)
      ein[i] = {j[i], k[i], p_n[i]};
    clr_n = c_n;
    repeat (3) @(negedge clk);
  endtask

  // pin low long enough for the synchroniser, then settle after the rise
  task fall;
    @(negedge clk);
    pin = 1'b0;
    repeat (8) @(negedge clk);
    pin = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  task t_over;
    drv(2'h0, 2'h0, 2'h2, 1'b1);
    chk(2'h1, 2'h2);
    drv(2'h0, 2'h0, 2'h3, 1'b0);
    chk(2'h0, 2'h3);
    drv(2'h0, 2'h0, 2'h2, 1'b0);
    chk(2'h1, 2'h3);
    drv(2'h0, 2'h0, 2'h3, 1'b0);
    chk(2'h0, 2'h3);
    drv(2'h0, 2'h0, 2'h3, 1'b1);
    chk(2'h0, 2'h3);
    drv(2'h0, 2'h0, 2'h1, 1'b1);
    chk(2'h2, 2'h1);
    drv(2'h0, 2'h0, 2'h1, 1'b0);
    chk(2'h2, 2'h3);
    // both controls released in one cycle: true output stays set
    drv(2'h0, 2'h0, 2'h3, 1'b1);
    chk(2'h2, 2'h1);
  endtask

  task t_jk;
    drv(2'h3, 2'h0, 2'h3, 1'b1);
    fall();
    chk(2'h3, 2'h0);
    drv(2'h0, 2'h0, 2'h3, 1'b1);
    fall();
    chk(2'h3, 2'h0);
    drv(2'h1, 2'h2, 2'h3, 1'b1);
    fall();
    chk(2'h1, 2'h2);
    drv(2'h3, 2'h3, 2'h3, 1'b1);
    fall();
    chk(2'h2, 2'h1);
    // clock held high with toggle inputs: nothing may move
    repeat (20) @(negedge clk);
    chk(2'h2, 2'h1);
    fall();
    chk(2'h1, 2'h2);
  endtask

  task t_late;
    @(negedge clk);
    pin = 1'b0;
    repeat (7) @(negedge clk);
    chk(2'h2, 2'h1);
    drv(2'h0, 2'h3, 2'h3, 1'b1);
    pin = 1'b1;
    repeat (8) @(negedge clk);
    chk(2'h2, 2'h1);
    fall();
    chk(2'h0, 2'h3);
  endtask

  initial
  begin
    // about ten times the expected length of the run
    #20000;
    n_mismatch++;
    summarize();
  end

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    pin = 1'b1;
    clr_n = 1'b1;
    ein = {3'h1, 3'h1};
    n_mismatch = 0;
    comparisons = 0;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    chk(2'h0, 2'h3);
    t_over();
    t_jk();
    t_late();
    summarize();
  end
endmodule
